/* core/bier_pin_element.sv */
`timescale 1ns/1ns
`include "bier_regs.svh"

// Overview of operation
// R1: One flip-flop per pin element serves either as input capture register or output register.
// R2: A pin element works as pure input, pure output, or bidirectional under its output enable.
// R3: Signals from the core routing can each be inverted by configuration; the code inverts only data, output enable and clock enable.
// R4: Each pin has its own output enable, so open drain can be emulated with data held low.
// R5: The pin flip-flop takes its configured high or low value once configuration has finished.
// R6: With a low initial value an asynchronous clear forces the flip-flop to zero at any time.
// R7: In the basic variant a high initial value allows neither asynchronous clear nor preset.
// R8: In the enhanced variant a high initial value allows an asynchronous preset to one.
// R9: The enhanced variant drives low or releases the pin natively in open-drain mode.
// R10: In the enhanced variant output-enable and input registers sit in the neighbour logic block.
// R11: Each enhanced programmable delay, clock enable included, is off or one of three levels.
// R12: Fast bidirectional pins distribute clock, clear or logic and can drive out from local routing.
// R13: Pins stay undriven until operating conditions are reached and configuration is complete.
// R14: The enhanced variant may drive its pins once powered, before configuration ends.
// R15: Chip-wide reset forces the flip-flops to their reset state and chip output enable low floats all.
// R16: The pin flip-flops update only on a clock edge with clock enable asserted, else they hold.
module bier_pin_element (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Configuration.
  input wire logic enhanced_in,
  input wire bier_pkg::bier_dir_t dir_mode_in,
  input wire bier_pkg::bier_role_t reg_role_in,
  input wire logic inv_data_in,
  input wire logic inv_oe_in,
  input wire logic inv_ce_in,
  input wire logic power_up_high_in,
  input wire logic open_drain_in,
  input wire bier_pkg::bier_dly_t dly_pin_core_in,
  input wire bier_pkg::bier_dly_t dly_pin_reg_in,
  input wire bier_pkg::bier_dly_t dly_core_reg_in,
  input wire bier_pkg::bier_dly_t dly_tco_in,
  input wire bier_pkg::bier_dly_t dly_ce_in,
  // Device state pins.
  input wire logic power_good_in,
  input wire logic config_done_in,
  input wire logic chip_reset_in,
  input wire logic chip_oe_in,
  // Core routing side.
  input wire logic core_data_in,
  input wire logic core_oe_in,
  input wire logic capture_enable_in,
  input wire logic async_clear_n_in,
  input wire logic async_preset_n_in,
  output logic core_reg_data_out,
  output logic core_pin_data_out,
  output logic user_active_out,
  // Pin side.
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  // Fast bidirectional pins and their local routing.
  input wire logic [`BIER_FAST_PINS-1:0] fast_bidir_pin_in,
  input wire logic [`BIER_FAST_PINS-1:0] fast_data_in,
  input wire logic [`BIER_FAST_PINS-1:0] fast_oe_in,
  output logic [`BIER_FAST_PINS-1:0] fast_dist_out,
  output logic [`BIER_FAST_PINS-1:0] fast_bidir_pin_out,
  output logic [`BIER_FAST_PINS-1:0] fast_bidir_pin_oe_out
);
  import bier_pkg::*;

  logic [`BIER_SYNC_W-1:0] sync1_ff;
  logic [`BIER_SYNC_W-1:0] sync2_ff;
  logic elem_q_ff;
  logic nxt_elem_q;
  logic oe_cell_ff;
  logic nxt_oe_cell;
  logic in_cell_ff;
  logic nxt_in_cell;
  logic data_src;
  logic oe_src;
  logic ce_src;
  logic data_dly;
  logic ce_dly;
  logic pin_reg_dly;
  logic pin_core_dly;
  logic q_tco;
  logic live;
  logic chip_rst_s;
  logic force_low;
  logic force_high;
  logic dir_drive;
  logic elem_is_out;

  // Every pin-side level is synchronised here; only the asynchronous force_low and force_high terms read chip_reset_in unsynchronised.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {fast_bidir_pin_in, chip_reset_in, chip_oe_in, config_done_in,
                   power_good_in, pin_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign chip_rst_s = sync2_ff[`BIER_S_CHIPRST];
  // The enhanced part only waits for power; the basic part also waits for configuration.
  assign live = enhanced_in ? sync2_ff[`BIER_S_PGOOD] // see R14
                            : (sync2_ff[`BIER_S_PGOOD] & sync2_ff[`BIER_S_CFG]); // see R13

  assign data_src = core_data_in ^ inv_data_in; // see R3
  assign oe_src = core_oe_in ^ inv_oe_in; // see R3
  assign ce_src = capture_enable_in ^ inv_ce_in; // see R3

  bier_delay_line u_dly_core_reg (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enhanced_in(enhanced_in),
    .setting_in(dly_core_reg_in),
    .data_in(data_src),
    .data_out(data_dly)
  );

  bier_delay_line u_dly_ce (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enhanced_in(enhanced_in),
    .setting_in(enhanced_in ? dly_ce_in : `BIER_DLY_OFF),
    .data_in(ce_src),
    .data_out(ce_dly)
  );

  bier_delay_line u_dly_pin_reg (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enhanced_in(enhanced_in),
    .setting_in(dly_pin_reg_in),
    .data_in(sync2_ff[`BIER_S_PIN]),
    .data_out(pin_reg_dly)
  );

  bier_delay_line u_dly_pin_core (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enhanced_in(enhanced_in),
    .setting_in(dly_pin_core_in),
    .data_in(sync2_ff[`BIER_S_PIN]),
    .data_out(pin_core_dly)
  );

  bier_delay_line u_dly_tco (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enhanced_in(enhanced_in),
    .setting_in(dly_tco_in),
    .data_in(elem_q_ff),
    .data_out(q_tco)
  );

  // The enhanced element only ever holds the output register.
  assign elem_is_out = enhanced_in || (reg_role_in == BIER_ROLE_OUTPUT); // see R10

  // The asynchronous terms only ever load constants.
  assign force_low = !power_up_high_in && (chip_reset_in || !async_clear_n_in); // see R6
  assign force_high = power_up_high_in && enhanced_in
                      && (chip_reset_in || !async_preset_n_in); // see R8

  always_comb begin
    nxt_elem_q = elem_q_ff;
    if (reset_in || !live || chip_rst_s) begin
      nxt_elem_q = power_up_high_in ? `BIER_PU_HIGH : `BIER_PU_LOW; // see R5
    end else if (ce_dly) begin // see R16
      if (elem_is_out) begin
        nxt_elem_q = data_dly; // see R1
      end else if (reg_role_in == BIER_ROLE_INPUT) begin
        nxt_elem_q = pin_reg_dly; // see R1
      end
    end
  end

  // A basic high-value register has no asynchronous term at all, only the clocked load.
  always_ff @(posedge clk_in or posedge force_low or posedge force_high) begin // see R7
    if (force_low) begin
      elem_q_ff <= `BIER_PU_LOW; // see R15
    end else if (force_high) begin
      elem_q_ff <= `BIER_PU_HIGH; // see R15
    end else begin
      elem_q_ff <= nxt_elem_q;
    end
  end

  // Neighbour-block cells for the enhanced variant: output enable and input capture.
  always_comb begin
    nxt_oe_cell = oe_cell_ff;
    nxt_in_cell = in_cell_ff;
    if (reset_in || chip_rst_s || !live) begin
      nxt_oe_cell = 1'h0;
      nxt_in_cell = 1'h0;
    end else if (ce_dly) begin // see R16
      nxt_oe_cell = oe_src; // see R10
      nxt_in_cell = pin_reg_dly; // see R10
    end
  end

  always_ff @(posedge clk_in) begin
    oe_cell_ff <= nxt_oe_cell;
    in_cell_ff <= nxt_in_cell;
  end

  always_comb begin
    case (dir_mode_in)
      BIER_DIR_INPUT: dir_drive = 1'h0; // see R2
      BIER_DIR_OUTPUT: dir_drive = 1'h1; // see R2
      BIER_DIR_BIDIR: dir_drive = enhanced_in ? oe_cell_ff : oe_src; // see R4
      default: dir_drive = 1'h0;
    endcase
  end

  always_comb begin
    pin_out = elem_is_out ? q_tco : data_src;
    pin_oe_out = dir_drive;
    if (enhanced_in && open_drain_in) begin
      pin_out = 1'h0; // see R9
      pin_oe_out = dir_drive && !(elem_is_out ? q_tco : data_src); // see R9
    end
    if (!live || !sync2_ff[`BIER_S_CHIPOE]) begin
      pin_oe_out = 1'h0; // see R13
    end
  end

  assign core_reg_data_out = enhanced_in ? in_cell_ff : elem_q_ff;
  assign core_pin_data_out = pin_core_dly;
  assign user_active_out = live;

  // Fast pins bypass the element register; drive comes straight from local routing.
  for (genvar i = 0; i < `BIER_FAST_PINS; i++) begin : g_fast
    assign fast_dist_out[i] = sync2_ff[`BIER_S_FAST + i]; // see R12
    assign fast_bidir_pin_out[i] = fast_data_in[i]; // see R12
    assign fast_bidir_pin_oe_out[i] = fast_oe_in[i] && live && sync2_ff[`BIER_S_CHIPOE]; // see R12
  end

  a_unconfig_no_drive: assert property (@(posedge clk_in) // see R13
    (!enhanced_in && !(sync2_ff[`BIER_S_PGOOD] && sync2_ff[`BIER_S_CFG])) |-> !pin_oe_out)
    else $error("Basic pin drives before configuration completes.");

  a_chip_oe_float: assert property (@(posedge clk_in) disable iff (reset_in) // see R15
    !sync2_ff[`BIER_S_CHIPOE] |-> (!pin_oe_out && fast_bidir_pin_oe_out == '0))
    else $error("A pin drives while chip output enable is low.");

  a_input_never_drives: assert property (@(posedge clk_in) // see R2
    dir_mode_in == BIER_DIR_INPUT |-> !pin_oe_out)
    else $error("Input-only pin is driven.");

  a_hold_no_enable: assert property (@(posedge clk_in) disable iff (reset_in) // see R16
    (live && !ce_dly && !chip_rst_s && !force_low && !force_high
     ##1 live && !chip_rst_s && !force_low && !force_high) |-> $stable(elem_q_ff))
    else $error("Element register changed without clock enable.");

  a_clear_forces_zero: assert property (@(posedge clk_in) // see R6
    (!power_up_high_in && !async_clear_n_in) |-> !elem_q_ff)
    else $error("Asynchronous clear did not force zero.");

  a_preset_forces_one: assert property (@(posedge clk_in) // see R8
    (enhanced_in && power_up_high_in && !async_preset_n_in) |-> elem_q_ff)
    else $error("Asynchronous preset did not force one.");

  a_basic_high_ignores: assert property (@(posedge clk_in) disable iff (reset_in) // see R7
    (!enhanced_in && power_up_high_in && (!async_clear_n_in || !async_preset_n_in)
     && !ce_dly && live && !chip_rst_s && !chip_reset_in) |=> $stable(elem_q_ff))
    else $error("Basic high-value register reacted to an asynchronous term.");

  a_power_up_value: assert property (@(posedge clk_in) disable iff (reset_in) // see R5
    ($rose(live) && !force_low && !force_high && !chip_rst_s)
    |-> elem_q_ff == power_up_high_in)
    else $error("Element register lacks its power-up value.");

  a_open_drain_low: assert property (@(posedge clk_in) // see R9
    (enhanced_in && open_drain_in) |-> (!pin_out && (!pin_oe_out || !q_tco || !elem_is_out)))
    else $error("Open-drain pin drives high.");

endmodule

/* shared/bier_regs.svh */
`ifndef BIER_REGS_SVH
`define BIER_REGS_SVH

// Delay chain settings: off, then three levels of one, two and three clock cycles.
`define BIER_DLY_OFF 2'h0
`define BIER_DLY_LVL1 2'h1
`define BIER_DLY_LEVELS 3

// Power-up values of the pin element flip-flop.
`define BIER_PU_LOW 1'h0
`define BIER_PU_HIGH 1'h1

// Number of dedicated fast bidirectional pins.
`define BIER_FAST_PINS 4

// Synchroniser bit positions.
`define BIER_S_PIN 0
`define BIER_S_PGOOD 1
`define BIER_S_CFG 2
`define BIER_S_CHIPOE 3
`define BIER_S_CHIPRST 4
`define BIER_S_FAST 5
`define BIER_SYNC_W 9

`endif

/* shared/bier_pkg.sv */
package bier_pkg;

  typedef enum logic [1:0] {
    BIER_DIR_INPUT,
    BIER_DIR_OUTPUT,
    BIER_DIR_BIDIR
  } bier_dir_t;

  typedef enum logic [1:0] {
    BIER_ROLE_NONE,
    BIER_ROLE_INPUT,
    BIER_ROLE_OUTPUT
  } bier_role_t;

  typedef logic [1:0] bier_dly_t;

endpackage

/* core/bier_delay_line.sv */
`timescale 1ns/1ns
`include "bier_regs.svh"

module bier_delay_line #(
  parameter int LEVELS = `BIER_DLY_LEVELS
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Path.
  input wire logic enhanced_in,
  input wire bier_pkg::bier_dly_t setting_in,
  input wire logic data_in,
  output logic data_out
);
  import bier_pkg::*;

  logic [LEVELS-1:0] tap_ff;
  logic [LEVELS-1:0] nxt_tap;
  bier_dly_t eff_setting;

  always_comb begin
    nxt_tap = {tap_ff[LEVELS-2:0], data_in};
    // The basic element has only an on/off delay, so any level collapses to the first.
    if (!enhanced_in && setting_in != `BIER_DLY_OFF) begin // see R11
      eff_setting = `BIER_DLY_LVL1;
    end else begin
      eff_setting = setting_in;
    end
    if (eff_setting == `BIER_DLY_OFF) begin // see R11
      data_out = data_in;
    end else begin
      data_out = tap_ff[eff_setting - `BIER_DLY_LVL1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tap_ff <= '0;
    end else begin
      tap_ff <= nxt_tap;
    end
  end

  a_delay_level_one: assert property (@(posedge clk_in) disable iff (reset_in)
    (eff_setting == `BIER_DLY_LVL1 && !$past(reset_in))
    |-> data_out == $past(data_in)) // see R11
    else $error("Delay level one does not delay by one cycle.");

endmodule

/* verification/bier_board_model.sv */
`timescale 1ns/1ns

// Board side of the pin and of the fast pins. A pull-up holds every line that nobody
// drives, so a released pin never shows a stale level from the device.
module bier_board_model (
  // Device drive.
  input wire logic dev_pin_in,
  input wire logic dev_oe_in,
  input wire logic [3:0] dev_fast_in,
  input wire logic [3:0] dev_fast_oe_in,
  // Board drive.
  input wire logic board_en_in,
  input wire logic board_val_in,
  input wire logic [3:0] fboard_en_in,
  input wire logic [3:0] fboard_val_in,
  // Resolved levels.
  output logic pin_level_out,
  output logic [3:0] fast_level_out
);
  assign pin_level_out = dev_oe_in ? dev_pin_in : (board_en_in ? board_val_in : 1'h1);
  assign fast_level_out = (dev_fast_oe_in & dev_fast_in) |
    (~dev_fast_oe_in & (~fboard_en_in | fboard_val_in));
endmodule

/* verification/bier_pin_element_tb.sv */
`timescale 1ns/1ns
`include "bier_regs.svh"

module bier_pin_element_tb;
  import bier_pkg::*;
  logic clk_in, reset_in, enhanced_in, inv_data_in, inv_oe_in, inv_ce_in, power_up_high_in;
  logic open_drain_in, power_good_in, config_done_in, chip_reset_in, chip_oe_in, core_data_in;
  logic core_oe_in, capture_enable_in, async_clear_n_in, async_preset_n_in, core_reg_data_out;
  logic core_pin_data_out, user_active_out, pin_in, pin_out, pin_oe_out, board_en, board_val, q;
  logic [`BIER_FAST_PINS-1:0] fast_bidir_pin_in, fast_data_in, fast_oe_in, fast_dist_out;
  logic [`BIER_FAST_PINS-1:0] fast_bidir_pin_out, fast_bidir_pin_oe_out, fboard_en, fboard_val;
  bier_dir_t dir_mode_in;
  bier_role_t reg_role_in;
  bier_dly_t dly;
  logic [15:0] lfsr;
  int n_mismatch, compares;

  bier_pin_element bier_pin_element_inst (.clk_in, .reset_in, .enhanced_in, .dir_mode_in,
    .reg_role_in, .inv_data_in, .inv_oe_in, .inv_ce_in, .power_up_high_in, .open_drain_in,
    .dly_pin_core_in(dly), .dly_pin_reg_in(dly), .dly_core_reg_in(dly), .dly_tco_in(dly),
    .dly_ce_in(dly), .power_good_in, .config_done_in, .chip_reset_in, .chip_oe_in,
    .core_data_in, .core_oe_in, .capture_enable_in, .async_clear_n_in, .async_preset_n_in,
    .core_reg_data_out, .core_pin_data_out, .user_active_out, .pin_in, .pin_out, .pin_oe_out,
    .fast_bidir_pin_in, .fast_data_in, .fast_oe_in, .fast_dist_out, .fast_bidir_pin_out,
    .fast_bidir_pin_oe_out);

  bier_board_model bier_board_model_inst (.dev_pin_in(pin_out), .dev_oe_in(pin_oe_out),
    .dev_fast_in(fast_bidir_pin_out), .dev_fast_oe_in(fast_bidir_pin_oe_out),
    .board_en_in(board_en), .board_val_in(board_val), .fboard_en_in(fboard_en),
    .fboard_val_in(fboard_val), .pin_level_out(pin_in), .fast_level_out(fast_bidir_pin_in));

  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Expected element flop after one edge, with the core inversions applied.
  function automatic logic flop_next(logic q0, logic d, logic ce, logic id, logic ic);
    return (ce ^ ic) ? (d ^ id) : q0;
  endfunction

  task automatic cyc(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(logic got, logic exp, string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic chk4(logic [3:0] got, logic [3:0] exp, string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(logic enh, logic puh);
    @(posedge clk_in);
    reset_in <= 1'h1;
    enhanced_in <= enh;
    power_up_high_in <= puh;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'h0;
    cyc(4);
  endtask

  // Capture enable is held several edges so that a delayed data path still lands.
  task automatic put_q(logic v);
    @(posedge clk_in);
    core_data_in <= v;
    capture_enable_in <= 1'h1;
    inv_data_in <= 1'h0;
    inv_ce_in <= 1'h0;
    repeat (5) @(posedge clk_in);
    capture_enable_in <= 1'h0;
    cyc(5);
  endtask

  task automatic async_pulse(logic clr, logic v, string m);
    @(posedge clk_in);
    async_clear_n_in <= !clr;
    async_preset_n_in <= clr;
    #1;
    chk(pin_out, v, m);
    @(posedge clk_in);
    async_clear_n_in <= 1'h1;
    async_preset_n_in <= 1'h1;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    {enhanced_in, inv_data_in, inv_oe_in, inv_ce_in, power_up_high_in} = '0;
    {open_drain_in, power_good_in, config_done_in, chip_reset_in, core_data_in} = '0;
    {core_oe_in, capture_enable_in, board_en, board_val, fast_data_in, fboard_en} = '0;
    {reset_in, chip_oe_in, async_clear_n_in, async_preset_n_in} = 4'hF;
    fast_oe_in = 4'hF;
    fboard_val = 4'h0;
    dir_mode_in = BIER_DIR_OUTPUT;
    reg_role_in = BIER_ROLE_OUTPUT;
    dly = 2'h0;
    lfsr = 16'h6F50;
    do_reset(1'h0, 1'h0);
    chk(pin_oe_out, 1'h0, "pin driven before power good");
    chk(user_active_out, 1'h0, "active before power good");
    chk4(fast_bidir_pin_oe_out, 4'h0, "fast pin driven early");
    @(posedge clk_in);
    power_good_in <= 1'h1;
    config_done_in <= 1'h1;
    cyc(4);
    chk(pin_oe_out, 1'h1, "output mode not driving");
    @(posedge clk_in);
    dir_mode_in <= BIER_DIR_INPUT;
    core_oe_in <= 1'h1;
    cyc(2);
    chk(pin_oe_out, 1'h0, "input mode driving");
    @(posedge clk_in);
    dir_mode_in <= BIER_DIR_BIDIR;
    q = 1'h0;
    repeat (40) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clk_in);
      core_data_in <= lfsr[0];
      capture_enable_in <= lfsr[1];
      inv_data_in <= lfsr[2];
      inv_ce_in <= lfsr[3];
      core_oe_in <= lfsr[4];
      inv_oe_in <= lfsr[5];
      cyc(1);
      q = flop_next(q, lfsr[0], lfsr[1], lfsr[2], lfsr[3]);
      chk(pin_out, q, "output flop value");
      chk(pin_oe_out, lfsr[4] ^ lfsr[5], "per pin enable");
    end
    put_q(1'h1);
    chk(pin_out, 1'h1, "capture failed");
    async_pulse(1'h1, 1'h0, "clear ignored");
    put_q(1'h1);
    @(posedge clk_in);
    chip_reset_in <= 1'h1;
    #1;
    chk(pin_out, 1'h0, "chip reset ignored");
    @(posedge clk_in);
    chip_reset_in <= 1'h0;
    do_reset(1'h0, 1'h1);
    chk(pin_out, 1'h1, "power-up high lost");
    async_pulse(1'h1, 1'h1, "clear acted on high flop");
    put_q(1'h0);
    async_pulse(1'h0, 1'h0, "preset acted in basic");
    dly = 2'h3;
    put_q(1'h1);
    chk(pin_out, 1'h1, "delayed path lost data");
    dly = 2'h0;
    @(posedge clk_in);
    config_done_in <= 1'h0;
    dir_mode_in <= BIER_DIR_OUTPUT;
    do_reset(1'h1, 1'h1);
    chk(pin_oe_out, 1'h1, "no drive before configuration");
    chk(user_active_out, 1'h1, "enhanced not active before configuration");
    put_q(1'h0);
    async_pulse(1'h0, 1'h1, "preset ignored");
    @(posedge clk_in);
    open_drain_in <= 1'h1;
    dir_mode_in <= BIER_DIR_OUTPUT;
    for (int v = 0; v < 2; v++) begin
      put_q(v[0]);
      chk(pin_out, 1'h0, "open drain drove high");
      chk(pin_oe_out, !v[0], "open drain enable");
    end
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clk_in);
      {open_drain_in, board_en, board_val, capture_enable_in} <= {2'h1, lfsr[0], 1'h1};
      config_done_in <= 1'h1;
      dir_mode_in <= BIER_DIR_INPUT;
      reg_role_in <= BIER_ROLE_INPUT;
      do_reset(i[1], 1'h0);
      chk(core_reg_data_out, lfsr[0], "input capture");
      chk(core_pin_data_out, lfsr[0], "pin to core path");
    end
    @(posedge clk_in);
    dir_mode_in <= BIER_DIR_OUTPUT;
    chip_oe_in <= 1'h0;
    cyc(4);
    chk(pin_oe_out, 1'h0, "chip enable low but driving");
    chk4(fast_bidir_pin_oe_out, 4'h0, "fast pin driving");
    lfsr = lfsr_next(lfsr);
    @(posedge clk_in);
    {chip_oe_in, fast_oe_in, fboard_en, fboard_val} <= {9'h10F, lfsr[3:0]};
    cyc(4);
    chk4(fast_dist_out, lfsr[3:0], "fast distribution");
    @(posedge clk_in);
    fast_oe_in <= 4'hF;
    fast_data_in <= lfsr[7:4];
    cyc(2);
    chk4(fast_bidir_pin_out, lfsr[7:4], "fast drive data");
    chk4(fast_bidir_pin_oe_out, 4'hF, "fast drive enable");
    end_sim();
  end
endmodule
